/* gpfc_pkg.sv */
// Shared constants and carrier types for the pin-function control block.
package gpfc_pkg;

  localparam int unsigned DATA_W        = 16;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned PIN_W         = 32;
  localparam int unsigned GRP_W         = 4;
  localparam int unsigned IRQ_W         = 2;
  localparam int unsigned SYNC_STAGES   = 2;

  // Register addresses.
  localparam logic [15:0] ADDR_CTRL     = 16'hC006;
  localparam logic [15:0] ADDR_OUT0     = 16'hC01E;
  localparam logic [15:0] ADDR_IN0      = 16'hC020;
  localparam logic [15:0] ADDR_DIR0     = 16'hC022;
  localparam logic [15:0] ADDR_OUT1     = 16'hC024;
  localparam logic [15:0] ADDR_IN1      = 16'hC026;
  localparam logic [15:0] ADDR_DIR1     = 16'hC028;
  localparam logic [15:0] ADDR_IRQ_STAT = 16'hC02A;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'hC02C;

  // Reset values and write masks.
  localparam logic [15:0] CTRL_RESET        = 16'h0000;
  localparam logic [15:0] CTRL_WMASK        = 16'h8FA3;
  localparam logic [15:0] CTRL_LOCKED_WMASK = 16'h00FF;
  localparam logic [15:0] IO_RESET          = 16'h0000;
  localparam logic [15:0] BANK1_MASK        = 16'hE1F8;
  localparam logic [15:0] RDATA_IDLE        = 16'h0000;
  localparam logic [1:0]  IRQ_RESET         = 2'h0;
  localparam logic [31:0] PIN_IMPL_MASK     = 32'hE1F8_FFFF;
  localparam logic [31:0] HPI_PIN_MASK      = 32'h01F8_FFFF;
  localparam logic [31:0] PADS_RESET        = 32'h0000_0000;

  // Control field positions.
  localparam int unsigned CTRL_LOCK_BIT  = 15;
  localparam int unsigned CTRL_SAS_BIT   = 11;
  localparam int unsigned CTRL_MODE_LSB  = 8;
  localparam int unsigned CTRL_FS_BIT    = 7;
  localparam int unsigned CTRL_SPI_BIT   = 5;
  localparam int unsigned CTRL_POL_BIT   = 1;
  localparam int unsigned CTRL_IRQEN_BIT = 0;

  // Pin groups.
  localparam int unsigned FS_PIN_LSB    = 12;
  localparam int unsigned SPI_PIN_LSB   = 8;
  localparam int unsigned SPI_SS_IDX    = 1;
  localparam int unsigned ALT_SS_PIN    = 15;
  localparam int unsigned IRQ_PIN       = 24;
  localparam int unsigned BANK1_PIN_LSB = 16;

  // Interrupt status bits.
  localparam int unsigned IRQ_PIN_EVT  = 0;
  localparam int unsigned IRQ_LOCK_EVT = 1;

  typedef enum logic [2:0] {
    GPFC_MODE_GPIO = 3'b000,
    GPFC_MODE_HPI  = 3'b101,
    GPFC_MODE_SCAN = 3'b110
  } gpfc_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } gpfc_bus_req_t;

  typedef struct packed {
    logic [GRP_W-1:0] out;
    logic [GRP_W-1:0] oe;
  } gpfc_grp_t;

  typedef struct packed {
    logic [PIN_W-1:0] out;
    logic [PIN_W-1:0] oe;
  } gpfc_pads_t;

endpackage

/* gpfc_pin_sync.sv */
// Two-flop synchroniser for a vector of asynchronous pin levels.
`timescale 1ns/1ps
module gpfc_pin_sync #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } gpfc_sync_t;

  gpfc_sync_t st_ff;
  gpfc_sync_t nxt_st;

  if (WIDTH < 1) begin : g_bad_width
    $error("gpfc_pin_sync needs WIDTH of at least one");
  end

  // The first stage feeds only the second stage.
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.meta   = d;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q = st_ff.stable;

endmodule // gpfc_pin_sync

/* gpfc_top.sv */
// Pin-function control: shared pin muxing, IO registers and the pin interrupt.
//
// Summary of operation
// - Lock bit freezes upper control byte until reset.
// - Mode 000 plain IO, 101 host port.
// - Fast serial routing puts that port on pins 15:12.
// - SPI routing puts the SPI port on pins 11:8.
// - Alternate select moves SPI slave select to pin 15.
// - Pin 24 interrupt edge follows the polarity bit.
// - Six IO registers at their fixed addresses.
// - Pin interrupt needs control bit 0 and enable.
// - Direction bit one drives the pin, zero listens.
// - Output data reads back the last written value masked to the implemented pins.
// - Input data reads the sampled pin levels.
`timescale 1ns/1ps
module gpfc_top (
  input  wire logic                                clock,
  input  wire logic                                rst_n,
  input  wire gpfc_pkg::gpfc_bus_req_t             bus_req,
  output logic      [gpfc_pkg::DATA_W-1:0]         bus_rdata,
  input  wire logic                                io_irq_enable,
  output logic                                     irq,
  input  wire logic [gpfc_pkg::PIN_W-1:0]          pad_in,
  output logic      [gpfc_pkg::PIN_W-1:0]          pad_out,
  output logic      [gpfc_pkg::PIN_W-1:0]          pad_oe,
  input  wire gpfc_pkg::gpfc_grp_t                 fast_serial_port_drv,
  output logic      [gpfc_pkg::GRP_W-1:0]          fast_serial_port_in,
  input  wire gpfc_pkg::gpfc_grp_t                 spi_drv,
  output logic      [gpfc_pkg::GRP_W-1:0]          spi_in,
  output logic                                     spi_slave_select_in,
  input  wire gpfc_pkg::gpfc_pads_t                host_port_interface_drv,
  output logic      [gpfc_pkg::PIN_W-1:0]          host_port_interface_in,
  output logic                                     host_port_interface_active
);

  typedef struct packed {
    logic [gpfc_pkg::DATA_W-1:0] ctrl;
    logic [gpfc_pkg::DATA_W-1:0] out0;
    logic [gpfc_pkg::DATA_W-1:0] dir0;
    logic [gpfc_pkg::DATA_W-1:0] out1;
    logic [gpfc_pkg::DATA_W-1:0] dir1;
    logic                        irq_pin_prev;
    logic [gpfc_pkg::IRQ_W-1:0]  irq_stat;
    logic [gpfc_pkg::IRQ_W-1:0]  irq_mask;
    logic [gpfc_pkg::DATA_W-1:0] rdata;
    logic                        irq;
    gpfc_pkg::gpfc_pads_t        pads;
    logic [gpfc_pkg::GRP_W-1:0]  fs_in;
    logic [gpfc_pkg::GRP_W-1:0]  spi_in;
    logic                        spi_ss;
    logic [gpfc_pkg::PIN_W-1:0]  hpi_in;
    logic                        hpi_active;
  } gpfc_state_t;

  gpfc_state_t                 st_ff;
  gpfc_state_t                 nxt_st;
  logic [gpfc_pkg::PIN_W-1:0]  pin_sync;

  // Pins come from outside the clock domain and are synchronised first.
  gpfc_pin_sync #(
    .WIDTH (gpfc_pkg::PIN_W)
  ) u_pin_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (pad_in),
    .q     (pin_sync)
  );

  // Refuse package settings that the fixed pin groups cannot serve.
  if (gpfc_pkg::PIN_W != 2 * gpfc_pkg::DATA_W) begin : g_bad_pin_w
    $error("gpfc_top needs PIN_W of twice DATA_W");
  end
  if (gpfc_pkg::IRQ_PIN >= gpfc_pkg::PIN_W) begin : g_bad_irq_pin
    $error("gpfc_top needs the interrupt pin inside the pad vector");
  end
  if (gpfc_pkg::IRQ_W > gpfc_pkg::DATA_W) begin : g_bad_irq_w
    $error("gpfc_top needs IRQ_W no wider than DATA_W");
  end
  if (gpfc_pkg::IRQ_LOCK_EVT >= gpfc_pkg::IRQ_W) begin : g_bad_evt
    $error("gpfc_top needs every status event inside IRQ_W");
  end
  if (gpfc_pkg::FS_PIN_LSB + gpfc_pkg::GRP_W > gpfc_pkg::DATA_W) begin : g_bad_fs_grp
    $error("gpfc_top needs the fast serial group inside bank 0");
  end
  if (gpfc_pkg::SPI_PIN_LSB + gpfc_pkg::GRP_W > gpfc_pkg::DATA_W) begin : g_bad_spi_grp
    $error("gpfc_top needs the SPI group inside bank 0");
  end
  if (gpfc_pkg::SPI_SS_IDX >= gpfc_pkg::GRP_W) begin : g_bad_ss_idx
    $error("gpfc_top needs the select index inside the SPI group");
  end

  // Combinational helpers derived from the current state.
  logic [2:0]                  mode_code;
  logic                        lock_on;
  logic                        sas_on;
  logic                        fs_on;
  logic                        spi_on;
  logic                        pol_rise;
  logic                        irq_pin_now;
  logic                        pin_edge;
  logic [gpfc_pkg::DATA_W-1:0] ctrl_wmask;
  logic [gpfc_pkg::PIN_W-1:0]  gpio_out;
  logic [gpfc_pkg::PIN_W-1:0]  gpio_oe;
  logic [gpfc_pkg::IRQ_W-1:0]  evt_set;
  logic [gpfc_pkg::IRQ_W-1:0]  evt_clr;
  logic [gpfc_pkg::IRQ_W-1:0]  irq_gate;
  logic                        wr_ctrl;

  always_comb begin
    mode_code  = st_ff.ctrl[gpfc_pkg::CTRL_MODE_LSB +: 3];
    lock_on    = st_ff.ctrl[gpfc_pkg::CTRL_LOCK_BIT];
    sas_on     = st_ff.ctrl[gpfc_pkg::CTRL_SAS_BIT];
    fs_on      = st_ff.ctrl[gpfc_pkg::CTRL_FS_BIT];
    spi_on     = st_ff.ctrl[gpfc_pkg::CTRL_SPI_BIT];
    pol_rise   = st_ff.ctrl[gpfc_pkg::CTRL_POL_BIT];
    irq_pin_now = pin_sync[gpfc_pkg::IRQ_PIN];
    wr_ctrl    = bus_req.wr && (bus_req.addr == gpfc_pkg::ADDR_CTRL);

    // The lock bit itself sits in the protected byte, so only reset clears it.
    ctrl_wmask = lock_on ? (gpfc_pkg::CTRL_WMASK & gpfc_pkg::CTRL_LOCKED_WMASK)
                         : gpfc_pkg::CTRL_WMASK;

    // Edge on the interrupt pin in the direction chosen by the polarity bit.
    pin_edge = pol_rise ? (irq_pin_now && !st_ff.irq_pin_prev)
                        : (!irq_pin_now && st_ff.irq_pin_prev);

    // Plain IO view of the pads, bank 1 bit k maps to pin 16 plus k.
    gpio_out = {st_ff.out1 & gpfc_pkg::BANK1_MASK, st_ff.out0};
    gpio_oe  = {st_ff.dir1 & gpfc_pkg::BANK1_MASK, st_ff.dir0};

    evt_set                          = '0;
    evt_set[gpfc_pkg::IRQ_PIN_EVT]   = pin_edge;
    evt_set[gpfc_pkg::IRQ_LOCK_EVT]  = wr_ctrl && lock_on;
    evt_clr = (bus_req.wr && (bus_req.addr == gpfc_pkg::ADDR_IRQ_STAT))
              ? bus_req.wdata[gpfc_pkg::IRQ_W-1:0] : '0;

    // The pin event reaches the output only with both enables set.
    irq_gate                         = '1;
    irq_gate[gpfc_pkg::IRQ_PIN_EVT]  = st_ff.ctrl[gpfc_pkg::CTRL_IRQEN_BIT]
                                       && io_irq_enable;
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.irq_pin_prev = irq_pin_now;

    // Register writes.
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        gpfc_pkg::ADDR_CTRL: begin
          nxt_st.ctrl = (st_ff.ctrl & ~ctrl_wmask)
                      | (bus_req.wdata & ctrl_wmask);
        end
        gpfc_pkg::ADDR_OUT0: begin
          nxt_st.out0 = bus_req.wdata;
        end
        gpfc_pkg::ADDR_DIR0: begin
          nxt_st.dir0 = bus_req.wdata;
        end
        gpfc_pkg::ADDR_OUT1: begin
          nxt_st.out1 = bus_req.wdata & gpfc_pkg::BANK1_MASK;
        end
        gpfc_pkg::ADDR_DIR1: begin
          nxt_st.dir1 = bus_req.wdata & gpfc_pkg::BANK1_MASK;
        end
        gpfc_pkg::ADDR_IRQ_MASK: begin
          nxt_st.irq_mask = bus_req.wdata[gpfc_pkg::IRQ_W-1:0];
        end
        default: begin
          nxt_st.ctrl = st_ff.ctrl;
        end
      endcase
    end

    // Sticky status: a new event wins over a clear in the same cycle.
    nxt_st.irq_stat = (st_ff.irq_stat & ~evt_clr) | evt_set;
    nxt_st.irq      = |(st_ff.irq_stat & st_ff.irq_mask & irq_gate);

    // Read data stand in the cycle after the strobe and only there.
    nxt_st.rdata = gpfc_pkg::RDATA_IDLE;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        gpfc_pkg::ADDR_CTRL: begin
          nxt_st.rdata = st_ff.ctrl & gpfc_pkg::CTRL_WMASK;
        end
        gpfc_pkg::ADDR_OUT0: begin
          nxt_st.rdata = st_ff.out0;
        end
        gpfc_pkg::ADDR_IN0: begin
          nxt_st.rdata = pin_sync[gpfc_pkg::BANK1_PIN_LSB-1:0];
        end
        gpfc_pkg::ADDR_DIR0: begin
          nxt_st.rdata = st_ff.dir0;
        end
        gpfc_pkg::ADDR_OUT1: begin
          nxt_st.rdata = st_ff.out1;
        end
        gpfc_pkg::ADDR_IN1: begin
          nxt_st.rdata = pin_sync[gpfc_pkg::PIN_W-1:gpfc_pkg::BANK1_PIN_LSB]
                         & gpfc_pkg::BANK1_MASK;
        end
        gpfc_pkg::ADDR_DIR1: begin
          nxt_st.rdata = st_ff.dir1;
        end
        gpfc_pkg::ADDR_IRQ_STAT: begin
          nxt_st.rdata = {{(gpfc_pkg::DATA_W-gpfc_pkg::IRQ_W){1'b0}}, st_ff.irq_stat};
        end
        gpfc_pkg::ADDR_IRQ_MASK: begin
          nxt_st.rdata = {{(gpfc_pkg::DATA_W-gpfc_pkg::IRQ_W){1'b0}}, st_ff.irq_mask};
        end
        default: begin
          nxt_st.rdata = gpfc_pkg::RDATA_IDLE;
        end
      endcase
    end

    // Pad muxing, lowest priority first; later owners override earlier ones.
    nxt_st.pads.out = gpio_out;
    nxt_st.pads.oe  = gpio_oe;
    if (spi_on) begin
      nxt_st.pads.out[gpfc_pkg::SPI_PIN_LSB +: gpfc_pkg::GRP_W] = spi_drv.out;
      nxt_st.pads.oe[gpfc_pkg::SPI_PIN_LSB +: gpfc_pkg::GRP_W]  = spi_drv.oe;
      if (sas_on) begin
        // Pin 9 goes back to plain IO once the select has moved.
        nxt_st.pads.out[gpfc_pkg::SPI_PIN_LSB + gpfc_pkg::SPI_SS_IDX] =
          gpio_out[gpfc_pkg::SPI_PIN_LSB + gpfc_pkg::SPI_SS_IDX];
        nxt_st.pads.oe[gpfc_pkg::SPI_PIN_LSB + gpfc_pkg::SPI_SS_IDX] =
          gpio_oe[gpfc_pkg::SPI_PIN_LSB + gpfc_pkg::SPI_SS_IDX];
      end
    end
    if (fs_on) begin
      nxt_st.pads.out[gpfc_pkg::FS_PIN_LSB +: gpfc_pkg::GRP_W] = fast_serial_port_drv.out;
      nxt_st.pads.oe[gpfc_pkg::FS_PIN_LSB +: gpfc_pkg::GRP_W]  =
        fast_serial_port_drv.oe;
    end
    if (spi_on && sas_on) begin
      // The moved slave select is an input and outranks the fast serial port.
      nxt_st.pads.out[gpfc_pkg::ALT_SS_PIN] = 1'b0;
      nxt_st.pads.oe[gpfc_pkg::ALT_SS_PIN]  = 1'b0;
    end

    nxt_st.hpi_active = 1'b0;
    unique case (mode_code)
      gpfc_pkg::GPFC_MODE_HPI: begin
        nxt_st.hpi_active = 1'b1;
        nxt_st.pads.out = (nxt_st.pads.out & ~gpfc_pkg::HPI_PIN_MASK)
                        | (host_port_interface_drv.out & gpfc_pkg::HPI_PIN_MASK);
        nxt_st.pads.oe  = (nxt_st.pads.oe & ~gpfc_pkg::HPI_PIN_MASK)
                        | (host_port_interface_drv.oe & gpfc_pkg::HPI_PIN_MASK);
      end
      gpfc_pkg::GPFC_MODE_SCAN: begin
        // Scan test owns the pins elsewhere; this block releases them all.
        nxt_st.pads.oe = '0;
      end
      default: begin
        // Plain IO and the reserved codes keep the IO view.
        nxt_st.hpi_active = 1'b0;
      end
    endcase
    nxt_st.pads.out = nxt_st.pads.out & gpfc_pkg::PIN_IMPL_MASK;
    nxt_st.pads.oe  = nxt_st.pads.oe & gpfc_pkg::PIN_IMPL_MASK;

    // Inputs handed to the alternate functions.
    nxt_st.fs_in  = fs_on ? pin_sync[gpfc_pkg::FS_PIN_LSB +: gpfc_pkg::GRP_W] : '0;
    nxt_st.spi_in = spi_on ? pin_sync[gpfc_pkg::SPI_PIN_LSB +: gpfc_pkg::GRP_W] : '0;
    if (spi_on && sas_on) begin
      nxt_st.spi_in[gpfc_pkg::SPI_SS_IDX] = pin_sync[gpfc_pkg::ALT_SS_PIN];
    end
    nxt_st.spi_ss = nxt_st.spi_in[gpfc_pkg::SPI_SS_IDX];
    nxt_st.hpi_in = (mode_code == gpfc_pkg::GPFC_MODE_HPI)
                    ? (pin_sync & gpfc_pkg::HPI_PIN_MASK) : '0;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff.ctrl         <= gpfc_pkg::CTRL_RESET;
      st_ff.out0         <= gpfc_pkg::IO_RESET;
      st_ff.dir0         <= gpfc_pkg::IO_RESET;
      st_ff.out1         <= gpfc_pkg::IO_RESET;
      st_ff.dir1         <= gpfc_pkg::IO_RESET;
      st_ff.irq_pin_prev <= 1'b0;
      st_ff.irq_stat     <= gpfc_pkg::IRQ_RESET;
      st_ff.irq_mask     <= gpfc_pkg::IRQ_RESET;
      st_ff.rdata        <= gpfc_pkg::RDATA_IDLE;
      st_ff.irq          <= 1'b0;
      st_ff.pads.out     <= gpfc_pkg::PADS_RESET;
      st_ff.pads.oe      <= gpfc_pkg::PADS_RESET;
      st_ff.fs_in        <= '0;
      st_ff.spi_in       <= '0;
      st_ff.spi_ss       <= 1'b0;
      st_ff.hpi_in       <= gpfc_pkg::PADS_RESET;
      st_ff.hpi_active   <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus_rdata                  = st_ff.rdata;
  assign irq                        = st_ff.irq;
  assign pad_out                    = st_ff.pads.out;
  assign pad_oe                     = st_ff.pads.oe;
  assign fast_serial_port_in        = st_ff.fs_in;
  assign spi_in                     = st_ff.spi_in;
  assign spi_slave_select_in        = st_ff.spi_ss;
  assign host_port_interface_in     = st_ff.hpi_in;
  assign host_port_interface_active = st_ff.hpi_active;

endmodule // gpfc_top

/* gpfc_pad.sv */
// Pad cells sit outside this block, so this file holds no logic.

/* gpfc_top_assertions.sv */
// Concurrent checks on the ports of the pin-function control block.
`timescale 1ns/1ps
module gpfc_top_assertions (
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire gpfc_pkg::gpfc_bus_req_t bus_req,
  input wire logic [15:0]             bus_rdata,
  input wire logic                    io_irq_enable,
  input wire logic                    irq,
  input wire logic [31:0]             pad_out,
  input wire logic [31:0]             pad_oe,
  input wire logic [3:0]              spi_in,
  input wire logic                    spi_slave_select_in,
  input wire gpfc_pkg::gpfc_pads_t    host_port_interface_drv,
  input wire logic [31:0]             host_port_interface_in,
  input wire logic                    host_port_interface_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic       lock_ff;
  logic [7:0] up_ff;
  logic       lk_stat_ff;
  // Shadow of the control upper byte as it stood when the lock was taken.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_ff <= 1'b0;
      up_ff   <= 8'h00;
    end else if (bus_req.wr && bus_req.addr == gpfc_pkg::ADDR_CTRL && !lock_ff) begin
      lock_ff <= bus_req.wdata[15];
      up_ff   <= bus_req.wdata[15:8] & 8'h8F;
    end
  end
  // Mirror of the locked-write status bit, which the pin enables do not gate.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lk_stat_ff <= 1'b0;
    end else begin
      lk_stat_ff <= (lk_stat_ff && !(bus_req.wr && bus_req.addr == gpfc_pkg::ADDR_IRQ_STAT
                                     && bus_req.wdata[1]))
                    || (bus_req.wr && bus_req.addr == gpfc_pkg::ADDR_CTRL && lock_ff);
    end
  end
  function automatic logic mapped(input logic [15:0] a);
    return a inside {gpfc_pkg::ADDR_CTRL, gpfc_pkg::ADDR_OUT0, gpfc_pkg::ADDR_IN0,
      gpfc_pkg::ADDR_DIR0, gpfc_pkg::ADDR_OUT1, gpfc_pkg::ADDR_IN1, gpfc_pkg::ADDR_DIR1,
      gpfc_pkg::ADDR_IRQ_STAT, gpfc_pkg::ADDR_IRQ_MASK};
  endfunction
  sequence s_wr_out0;
    bus_req.wr && bus_req.addr == gpfc_pkg::ADDR_OUT0;
  endsequence
  sequence s_rd_out0;
    bus_req.rd && bus_req.addr == gpfc_pkg::ADDR_OUT0;
  endsequence
  property p_rd_idle;
    !$past(bus_req.rd) |-> bus_rdata == 16'h0000;
  endproperty
  property p_unmapped;
    bus_req.rd && !mapped(bus_req.addr) |=> bus_rdata == 16'h0000;
  endproperty
  property p_out_rbk;
    s_wr_out0 ##1 s_rd_out0 |=> bus_rdata == $past(bus_req.wdata, 2);
  endproperty
  property p_lock_hold;
    lock_ff && bus_req.rd && bus_req.addr == gpfc_pkg::ADDR_CTRL |=> bus_rdata[15:8] == up_ff;
  endproperty
  property p_pad_impl;
    ((pad_out | pad_oe) & ~gpfc_pkg::PIN_IMPL_MASK) == 32'h0000_0000;
  endproperty
  property p_ss_copy;
    spi_slave_select_in == spi_in[1];
  endproperty
  property p_irq_gate;
    !io_irq_enable && !lk_stat_ff |=> !irq;
  endproperty
  property p_hpi_in_off;
    !host_port_interface_active |-> host_port_interface_in == 32'h0000_0000;
  endproperty
  property p_hpi_drive;
    host_port_interface_active && $past(host_port_interface_active)
      && $stable(host_port_interface_drv)
      |-> ((pad_oe ^ host_port_interface_drv.oe) & gpfc_pkg::HPI_PIN_MASK) == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_out_rbk: assert property (p_out_rbk) else $error("output readback wrong");
  a_lock_hold: assert property (p_lock_hold) else $error("locked byte changed");
  a_pad_impl: assert property (p_pad_impl) else $error("absent pin driven");
  a_ss_copy: assert property (p_ss_copy) else $error("select copy differs");
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");
  a_hpi_in_off: assert property (p_hpi_in_off) else $error("host input leaks");
  a_hpi_drive: assert property (p_hpi_drive) else $error("host drive not owned");
endmodule // gpfc_top_assertions

bind gpfc_top gpfc_top_assertions gpfc_top_assertions_inst (
  .clock(clock), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .io_irq_enable(io_irq_enable), .irq(irq), .pad_out(pad_out), .pad_oe(pad_oe),
  .spi_in(spi_in), .spi_slave_select_in(spi_slave_select_in),
  .host_port_interface_drv(host_port_interface_drv),
  .host_port_interface_in(host_port_interface_in),
  .host_port_interface_active(host_port_interface_active)
);

/* gpio_pin_function_control_tb.sv */
// Self-checking testbench for the pin-function control block.
`timescale 1ns/1ps
module gpio_pin_function_control_tb;
  logic                    clock;
  logic                    rst_n;
  gpfc_pkg::gpfc_bus_req_t req;
  logic [15:0]             rdata;
  logic                    irq_en;
  logic                    irq;
  logic [31:0]             pad_in;
  logic [31:0]             pad_out;
  logic [31:0]             pad_oe;
  gpfc_pkg::gpfc_grp_t     fs_drv;
  gpfc_pkg::gpfc_grp_t     spi_drv;
  gpfc_pkg::gpfc_pads_t    hp_drv;
  logic [3:0]              fs_in;
  logic [3:0]              spi_in;
  logic                    ss_in;
  logic [31:0]             hp_in;
  logic                    hp_act;
  logic [15:0]             q;
  int                      n_mismatch;
  int                      total_checks;
  gpfc_top gpfc_top_inst (
    .clock(clock), .rst_n(rst_n), .bus_req(req), .bus_rdata(rdata),
    .io_irq_enable(irq_en), .irq(irq), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .fast_serial_port_drv(fs_drv), .fast_serial_port_in(fs_in),
    .spi_drv(spi_drv), .spi_in(spi_in), .spi_slave_select_in(ss_in),
    .host_port_interface_drv(hp_drv), .host_port_interface_in(hp_in),
    .host_port_interface_active(hp_act)
  );
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clock);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rchk(input string nm, input logic [15:0] a, input logic [15:0] e);
    @(posedge clock);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    chk(nm, rdata, e);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 20 && irq !== 1'b1; i++) cyc(1);
    chk("irq_wait", irq, 1'b1);
    if (irq !== 1'b1) final_report();
  endtask
  task automatic t_regs();
    logic [15:0] adr [10];
    logic [15:0] expv [10];
    adr = '{gpfc_pkg::ADDR_CTRL, gpfc_pkg::ADDR_OUT0, gpfc_pkg::ADDR_IN0, gpfc_pkg::ADDR_DIR0,
      gpfc_pkg::ADDR_OUT1, gpfc_pkg::ADDR_IN1, gpfc_pkg::ADDR_DIR1, gpfc_pkg::ADDR_IRQ_STAT,
      gpfc_pkg::ADDR_IRQ_MASK, 16'hC008};
    // Input registers already show the synchronised pin levels.
    expv = '{16'h0000, 16'h0000, 16'hA5C3, 16'h0000, 16'h0000, 16'hA0C8, 16'h0000,
      16'h0000, 16'h0000, 16'h0000};
    foreach (adr[i]) rchk("reset", adr[i], expv[i]);
  endtask
  task automatic t_io();
    @(posedge clock);
    req.addr  <= gpfc_pkg::ADDR_OUT0;
    req.wdata <= 16'h5A3C;
    req.wr    <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
    req.rd <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    chk("out0_b2b", rdata, 16'h5A3C);
    wr(gpfc_pkg::ADDR_DIR0, 16'h00FF);
    wr(gpfc_pkg::ADDR_OUT1, 16'hFFFF);
    wr(gpfc_pkg::ADDR_DIR1, 16'hFFFF);
    wr(gpfc_pkg::ADDR_IN0, 16'hFFFF);
    rchk("dir0", gpfc_pkg::ADDR_DIR0, 16'h00FF);
    rchk("out1", gpfc_pkg::ADDR_OUT1, 16'hE1F8);
    rchk("dir1", gpfc_pkg::ADDR_DIR1, 16'hE1F8);
    rchk("in0", gpfc_pkg::ADDR_IN0, 16'hA5C3);
    rchk("in1", gpfc_pkg::ADDR_IN1, 16'hA0C8);
    chk("oe", pad_oe, 32'hE1F8_00FF);
    chk("out", pad_out & pad_oe, 32'hE1F8_003C);
  endtask
  task automatic t_mux();
    wr(gpfc_pkg::ADDR_CTRL, 16'h00A0);
    cyc(2);
    chk("oe", pad_oe[15:8], 8'hFF);
    chk("pins", pad_out[15:8], 8'h5A);
    chk("fs_in", fs_in, 4'hA);
    chk("spi_in", {ss_in, spi_in}, 5'h05);
    wr(gpfc_pkg::ADDR_CTRL, 16'h08A0);
    cyc(2);
    chk("oe_alt", pad_oe[15:8], 8'h7D);
    chk("spi_alt", {ss_in, spi_in}, 5'h17);
    wr(gpfc_pkg::ADDR_CTRL, 16'h0000);
    cyc(2);
    chk("oe_free", pad_oe[15:8], 8'h00);
    chk("in_free", {fs_in, spi_in}, 8'h00);
  endtask
  task automatic t_modes();
    logic [2:0] m [5];
    m = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    wr(gpfc_pkg::ADDR_CTRL, 16'h0500);
    cyc(3);
    chk("act", hp_act, 1'b1);
    chk("hp_oe", pad_oe & gpfc_pkg::HPI_PIN_MASK, gpfc_pkg::HPI_PIN_MASK);
    chk("hp_in", hp_in, 32'h00C8_A5C3);
    foreach (m[i]) begin
      wr(gpfc_pkg::ADDR_CTRL, {5'h00, m[i], 8'h00});
      cyc(2);
      chk("act_rsv", hp_act, 1'b0);
      chk("oe_rsv", pad_oe, 32'hE1F8_00FF);
    end
    wr(gpfc_pkg::ADDR_CTRL, 16'h0600);
    cyc(2);
    chk("scan_oe", pad_oe, 32'h0000_0000);
    wr(gpfc_pkg::ADDR_CTRL, 16'h0000);
  endtask
  task automatic t_irq();
    wr(gpfc_pkg::ADDR_IRQ_STAT, 16'h0003);
    wr(gpfc_pkg::ADDR_IRQ_MASK, 16'h0003);
    wr(gpfc_pkg::ADDR_CTRL, 16'h0003);
    irq_en     <= 1'b1;
    pad_in[24] <= 1'b1;
    wait_irq();
    rchk("stat", gpfc_pkg::ADDR_IRQ_STAT, 16'h0001);
    wr(gpfc_pkg::ADDR_IRQ_STAT, 16'h0001);
    cyc(3);
    chk("clear", irq, 1'b0);
    @(posedge clock);
    pad_in[24] <= 1'b0;
    cyc(6);
    rchk("no_fall", gpfc_pkg::ADDR_IRQ_STAT, 16'h0000);
    wr(gpfc_pkg::ADDR_CTRL, 16'h0001);
    pad_in[24] <= 1'b1;
    cyc(6);
    rchk("no_rise", gpfc_pkg::ADDR_IRQ_STAT, 16'h0000);
    @(posedge clock);
    pad_in[24] <= 1'b0;
    wait_irq();
    @(posedge clock);
    irq_en <= 1'b0;
    cyc(2);
    chk("gate", irq, 1'b0);
    @(posedge clock);
    irq_en <= 1'b1;
    wait_irq();
    wr(gpfc_pkg::ADDR_IRQ_MASK, 16'h0000);
    cyc(3);
    chk("mask", irq, 1'b0);
    wr(gpfc_pkg::ADDR_IRQ_MASK, 16'h0001);
    wait_irq();
    wr(gpfc_pkg::ADDR_CTRL, 16'h0000);
    cyc(3);
    chk("en0", irq, 1'b0);
    wr(gpfc_pkg::ADDR_IRQ_STAT, 16'h0003);
  endtask
  task automatic t_lock();
    wr(gpfc_pkg::ADDR_CTRL, 16'h8000);
    wr(gpfc_pkg::ADDR_CTRL, 16'h0523);
    rchk("locked", gpfc_pkg::ADDR_CTRL, 16'h8023);
    rchk("lk_evt", gpfc_pkg::ADDR_IRQ_STAT, 16'h0002);
    chk("lk_act", hp_act, 1'b0);
    @(posedge clock);
    rst_n <= 1'b0;
    cyc(3);
    @(posedge clock);
    rst_n <= 1'b1;
    rchk("unlock", gpfc_pkg::ADDR_CTRL, 16'h0000);
  endtask
  initial begin
    rst_n        = 1'b0;
    req          = '0;
    irq_en       = 1'b0;
    pad_in       = 32'hA0C8_A5C3;
    fs_drv       = '{out: 4'h5, oe: 4'hF};
    spi_drv      = '{out: 4'hA, oe: 4'hF};
    hp_drv       = '{out: 32'h1234_5678, oe: 32'hFFFF_FFFF};
    n_mismatch   = 0;
    total_checks = 0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    t_regs();
    t_io();
    t_mux();
    t_modes();
    t_irq();
    t_lock();
    final_report();
  end
endmodule // gpio_pin_function_control_tb
